// ==== src/cir_dev.sv ====
// Purpose: Cascaded priority interrupt pair with daisy-chained serial vectors
// Assumes: Requests are levels synchronous to clk; ce low freezes all state
// Notes:   Vector answer one cycle after acknowledge
// Behaviour
// - Master and slave cascaded, fully nested mode
// - Master level n gives 60h plus n
// - Master 7 cascades; slave n gives 68h+n
// - Serial vectors in 70h, 80h, 90h ranges
// - Host dismisses master level with 60h+n
// - Host dismisses slave: slave 60h+n, master 67h
// - Host dismisses serial: 38h, then master 61h
// - Host loads serial bases 70h, 80h, 90h
// - Host sets status-modifies-vector in each controller
// - Vector offsets: B tx, ext, rx, special, A
// - Status-modifies-vector is WR1 bit 2, channel B
`timescale 1ns/1ps
module cir_dev
	import cir_pkg::*;
#(
	parameter int N_SER = cir_pkg::NUM_SER
) (
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic                    ce,
	cir_if.dev                           lnk,
	input  wire logic [5:0]              mreq,
	input  wire logic [7:0]              sreq,
	input  wire logic [N_SER-1:0][7:0]   ser_req,
	output logic      [7:0]              m_isr_r,
	output logic      [7:0]              s_isr_r,
	output logic      [N_SER-1:0]        ser_ius_r,
	output logic      [N_SER-1:0]        ser_sav_r
);
	import cir_pkg::*;

	function automatic logic [3:0] first_set(input logic [7:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 7; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, 3'(i)};
			end
		end
		return r;
	endfunction

	// Level mask of a 60h-plus-level dismissal code, zero otherwise
	function automatic logic [7:0] eoi_mask(input logic [7:0] d);
		logic [7:0] m;
		m = 8'h00;
		if (d[7:3] == EOI_BASE[7:3]) begin
			m[d[2:0]] = 1'b1;
		end
		return m;
	endfunction

	logic             irq_r;
	logic             vec_valid_r;
	logic [7:0]       vec_r;
	logic [7:0]       ser_base_r [N_SER];
	logic [7:0]       ser_base_nxt [N_SER];
	logic [N_SER-1:0] ser_sav_nxt;
	logic [N_SER-1:0] ser_wr_b;

	logic [7:0]       m_irr;
	logic [7:0]       m_ok;
	logic [7:0]       s_ok;
	logic [7:0]       ser_pend;
	logic [N_SER-1:0] ser_live;
	logic [3:0]       m_pick;
	logic [3:0]       s_pick;
	logic [3:0]       u_pick;
	logic [3:0]       c_pick;
	logic [7:0]       ser_sel_req;
	logic [7:0]       ser_vec;
	logic [7:0]       vec_nxt;
	logic             ack;
	logic [7:0]       m_set;
	logic [7:0]       s_set;
	logic [7:0]       m_clr;
	logic [7:0]       s_clr;
	logic [N_SER-1:0] ius_set;
	logic [N_SER-1:0] ius_clr;
	logic [2:0]       unit;
	logic             unit_ok;
	logic             cmd_eoi;

	assign lnk.irq       = irq_r;
	assign lnk.vec_valid = vec_valid_r;
	assign lnk.vec       = vec_r;

	// nested priority, each in-service bit blocks its level and all higher-numbered levels
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_nest
			assign m_ok[g] = m_irr[g] & ~(|m_isr_r[g:0]);
			assign s_ok[g] = sreq[g] & ~(|s_isr_r[g:0]);
		end
		// Daisy chain: a controller in service blocks itself and those behind it
		for (g = 0; g < N_SER; g++) begin : g_chain
			assign ser_live[g] = (|ser_req[g]) & ~(|ser_ius_r[g:0]);
		end
	endgenerate

	// slave output feeds master level 7; serial chain feeds level 1
	assign m_irr    = {(|s_ok), mreq[5:1], (|ser_live), mreq[0]};
	assign ser_pend = 8'(ser_live);
	assign m_pick   = first_set(m_ok);
	assign s_pick   = first_set(s_ok);
	assign u_pick   = first_set(ser_pend);
	assign unit     = u_pick[2:0];
	assign ser_sel_req = ser_req[unit[1:0]];
	assign c_pick   = first_set(ser_sel_req);

	// cause index sits in vector bits 3..1 when status modifies vector
	assign ser_vec = ser_sav_r[unit[1:0]]
		? {ser_base_r[unit[1:0]][7:4], c_pick[2:0], ser_base_r[unit[1:0]][0]}
		: ser_base_r[unit[1:0]];

	always_comb begin
		vec_nxt = VEC_CLEANUP;
		m_set   = 8'h00;
		s_set   = 8'h00;
		ius_set = '0;
		if (ack && m_pick[3]) begin
			m_set[m_pick[2:0]] = 1'b1;
			if (m_pick[2:0] == CASCADE_LVL) begin
				// slave level n answers 68h plus n
				vec_nxt = VEC_SLAVE_BASE + {5'h00, s_pick[2:0]};
				s_set[s_pick[2:0]] = 1'b1;
			end else if (m_pick[2:0] == SERIAL_LVL) begin
				// vector taken from the chosen controller's own base
				vec_nxt = ser_vec;
				ius_set[unit[1:0]] = 1'b1;
			end else begin
				// master level n answers 60h plus n
				vec_nxt = VEC_MASTER_BASE + {5'h00, m_pick[2:0]};
			end
		end
	end

	// Ack taken on every enabled edge; an empty ack answers cleanup
	assign ack     = lnk.inta;
	assign unit_ok = lnk.cmd_unit < 2'(N_SER);
	// dismissal code on channel A register 0 ends controller service
	assign cmd_eoi = lnk.cmd_valid && lnk.cmd_port == CP_SER_A
		&& lnk.cmd_reg == CR_WR0 && lnk.cmd_data == SER_EOI_CODE && unit_ok;

	// master in-service cleared by 60h plus level
	assign m_clr = (lnk.cmd_valid && lnk.cmd_port == CP_MASTER)
		? eoi_mask(lnk.cmd_data) : 8'h00;
	// slave in-service cleared by 60h plus level on slave port
	assign s_clr = (lnk.cmd_valid && lnk.cmd_port == CP_SLAVE)
		? eoi_mask(lnk.cmd_data) : 8'h00;
	assign ius_clr = cmd_eoi ? N_SER'(1 << lnk.cmd_unit) : '0;

	// Every register below holds while ce is low
	// Acknowledge sets win over a dismissal in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			m_isr_r   <= 8'h00;
			s_isr_r   <= 8'h00;
			ser_ius_r <= '0;
		end else if (ce) begin
			m_isr_r   <= (m_isr_r & ~m_clr) | m_set;
			s_isr_r   <= (s_isr_r & ~s_clr) | s_set;
			ser_ius_r <= (ser_ius_r & ~ius_clr) | ius_set;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irq_r       <= 1'b0;
			vec_valid_r <= 1'b0;
			vec_r       <= 8'h00;
		end else if (ce) begin
			irq_r       <= |m_ok;
			vec_valid_r <= ack;
			if (ack) begin
				vec_r <= vec_nxt;
			end
		end
	end

	// base and status-modifies-vector only written through channel B
	generate
		for (g = 0; g < N_SER; g++) begin : g_ser
			assign ser_wr_b[g] = lnk.cmd_valid && lnk.cmd_port == CP_SER_B
				&& lnk.cmd_unit == 2'(g);
			// base lands from register 2 writes
			assign ser_base_nxt[g] = (ser_wr_b[g] && lnk.cmd_reg == CR_WR2)
				? lnk.cmd_data : ser_base_r[g];
			// vector status bit from register 1 writes
			assign ser_sav_nxt[g] = (ser_wr_b[g] && lnk.cmd_reg == CR_WR1)
				? lnk.cmd_data[SAV_BIT] : ser_sav_r[g];
		end
	endgenerate

	// One process owns every controller's base and status bit
	always_ff @(posedge clk) begin
		if (rst) begin
			ser_base_r <= '{default: SER_BASE_RST};
			ser_sav_r  <= '0;
		end else if (ce) begin
			ser_base_r <= ser_base_nxt;
			ser_sav_r  <= ser_sav_nxt;
		end
	end
endmodule

// ==== pkg/cir_pkg.sv ====
// Purpose: Shared constants and types for the cascaded interrupt routing pair
// Assumes: One clock, synchronous active-high reset
// Notes:   Vector and dismissal codes are byte values seen on the link
package cir_pkg;
	localparam int          NUM_SER         = 3;
	localparam logic [7:0]  VEC_MASTER_BASE = 8'h60;
	localparam logic [7:0]  VEC_SLAVE_BASE  = 8'h68;
	localparam logic [7:0]  VEC_CLEANUP     = 8'h6f;
	localparam logic [7:0]  VEC_SER_FIRST   = 8'h70;
	localparam logic [7:0]  VEC_SER_LAST    = 8'h9f;
	localparam logic [7:0]  EOI_BASE        = 8'h60;
	localparam logic [7:0]  EOI_CASCADE     = 8'h67;
	localparam logic [7:0]  EOI_SERIAL_LVL  = 8'h61;
	localparam logic [7:0]  SER_EOI_CODE    = 8'h38;
	localparam logic [7:0]  SER_BASE_ONB    = 8'h70;
	localparam logic [7:0]  SER_BASE_ASYNC  = 8'h80;
	localparam logic [7:0]  SER_BASE_SYNC   = 8'h90;
	localparam logic [7:0]  SER_BASE_RST    = 8'h00;
	localparam int          SAV_BIT         = 2;
	localparam logic [7:0]  WR1_INIT        = 8'h04;
	localparam logic [2:0]  SERIAL_LVL      = 3'h1;
	localparam logic [2:0]  CASCADE_LVL     = 3'h7;
	localparam logic [1:0]  GAP_CYCLES      = 2'h2;

	typedef enum logic [1:0] {
		CP_MASTER,
		CP_SLAVE,
		CP_SER_A,
		CP_SER_B
	} cir_port_t;

	typedef enum logic [1:0] {
		CR_WR0,
		CR_WR1,
		CR_WR2,
		CR_NONE
	} cir_reg_t;
endpackage

// ==== pkg/cir_if.sv ====
// Purpose: Link between the interrupt routing device and the servicing host
// Assumes: Both ends on the same clock
// Notes:   Acknowledge, vector answer and command write channels
`timescale 1ns/1ps
interface cir_if;
	import cir_pkg::*;
	logic            irq;
	logic            inta;
	logic            vec_valid;
	logic [7:0]      vec;
	logic            cmd_valid;
	cir_port_t       cmd_port;
	logic [1:0]      cmd_unit;
	cir_reg_t        cmd_reg;
	logic [7:0]      cmd_data;

	modport dev (
		output irq, vec_valid, vec,
		input  inta, cmd_valid, cmd_port, cmd_unit, cmd_reg, cmd_data
	);
	modport host (
		input  irq, vec_valid, vec,
		output inta, cmd_valid, cmd_port, cmd_unit, cmd_reg, cmd_data
	);
endinterface

// ==== src/cir_host.sv ====
// Purpose: Servicing end: programs serial vectors, acknowledges, dismisses
// Assumes: One interrupt in service at a time; ce low freezes all state
// Notes:   User sees each vector and signals when its handler is done
`timescale 1ns/1ps
module cir_host
	import cir_pkg::*;
#(
	parameter int N_SER = cir_pkg::NUM_SER
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       ce,
	cir_if.host             lnk,
	input  wire logic       svc_done,
	output logic            svc_valid_r,
	output logic [7:0]      svc_vec_r,
	output logic            ready_r
);
	import cir_pkg::*;

	typedef enum logic [3:0] {
		H_BASE, H_WR1, H_IDLE, H_ACK, H_WAITV, H_SVC, H_EOI1, H_EOI2, H_GAP
	} cir_hst_t;

	cir_hst_t     st_r;
	cir_hst_t     st_nxt;
	logic [1:0]   unit_r;
	logic [1:0]   gap_r;
	logic         inta_r;
	logic         cmd_valid_r;
	cir_port_t    cmd_port_r;
	logic [1:0]   cmd_unit_r;
	cir_reg_t     cmd_reg_r;
	logic [7:0]   cmd_data_r;

	logic         issue;
	cir_port_t    port_nxt;
	cir_reg_t     reg_nxt;
	logic [1:0]   cunit_nxt;
	logic [7:0]   data_nxt;
	logic         is_slave;
	logic         is_ser;
	logic [7:0]   base_sel;
	logic [1:0]   ser_unit;

	assign lnk.inta      = inta_r;
	assign lnk.cmd_valid = cmd_valid_r;
	assign lnk.cmd_port  = cmd_port_r;
	assign lnk.cmd_unit  = cmd_unit_r;
	assign lnk.cmd_reg   = cmd_reg_r;
	assign lnk.cmd_data  = cmd_data_r;

	assign is_slave = svc_vec_r[7:3] == VEC_SLAVE_BASE[7:3];
	assign is_ser   = svc_vec_r >= VEC_SER_FIRST && svc_vec_r <= VEC_SER_LAST;
	assign ser_unit = 2'(svc_vec_r[7:4] - VEC_SER_FIRST[7:4]);
	// bases 70h, 80h, 90h per controller
	assign base_sel = (unit_r == 2'h0) ? SER_BASE_ONB
		: (unit_r == 2'h1) ? SER_BASE_ASYNC : SER_BASE_SYNC;

	always_comb begin
		st_nxt    = st_r;
		issue     = 1'b0;
		port_nxt  = CP_MASTER;
		reg_nxt   = CR_NONE;
		cunit_nxt = 2'h0;
		data_nxt  = 8'h00;
		unique case (st_r)
			H_BASE: begin
				issue     = 1'b1;
				port_nxt  = CP_SER_B;
				reg_nxt   = CR_WR2;
				cunit_nxt = unit_r;
				data_nxt  = base_sel;
				st_nxt    = H_WR1;
			end
			H_WR1: begin
				// status-modifies-vector set, written via channel B
				issue     = 1'b1;
				port_nxt  = CP_SER_B;
				reg_nxt   = CR_WR1;
				cunit_nxt = unit_r;
				data_nxt  = WR1_INIT;
				st_nxt    = (unit_r == 2'(N_SER - 1)) ? H_IDLE : H_BASE;
			end
			H_IDLE: begin
				if (lnk.irq) begin
					st_nxt = H_ACK;
				end
			end
			H_ACK:   st_nxt = H_WAITV;
			H_WAITV: begin
				if (lnk.vec_valid) begin
					st_nxt = H_SVC;
				end
			end
			H_SVC: begin
				if (svc_done) begin
					st_nxt = H_EOI1;
				end
			end
			H_EOI1: begin
				issue = 1'b1;
				if (is_ser) begin
					// serial controller dismissed first on channel A
					port_nxt  = CP_SER_A;
					reg_nxt   = CR_WR0;
					cunit_nxt = ser_unit;
					data_nxt  = SER_EOI_CODE;
					st_nxt    = H_EOI2;
				end else if (is_slave) begin
					// slave dismissed first with 60h plus level
					port_nxt = CP_SLAVE;
					data_nxt = EOI_BASE + {5'h00, svc_vec_r[2:0]};
					st_nxt   = H_EOI2;
				end else begin
					// master level dismissed with 60h plus level
					data_nxt = EOI_BASE + {5'h00, svc_vec_r[2:0]};
					st_nxt   = H_GAP;
				end
			end
			H_EOI2: begin
				issue    = 1'b1;
				data_nxt = is_ser ? EOI_SERIAL_LVL : EOI_CASCADE;
				st_nxt   = H_GAP;
			end
			H_GAP: begin
				if (gap_r == GAP_CYCLES) begin
					st_nxt = H_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r   <= H_BASE;
			unit_r <= 2'h0;
			gap_r  <= 2'h0;
		end else if (ce) begin
			st_r   <= st_nxt;
			unit_r <= (st_r == H_WR1) ? unit_r + 2'h1 : unit_r;
			gap_r  <= (st_r == H_GAP) ? gap_r + 2'h1 : 2'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			inta_r      <= 1'b0;
			cmd_valid_r <= 1'b0;
			cmd_port_r  <= CP_MASTER;
			cmd_unit_r  <= 2'h0;
			cmd_reg_r   <= CR_NONE;
			cmd_data_r  <= 8'h00;
			svc_valid_r <= 1'b0;
			svc_vec_r   <= 8'h00;
			ready_r     <= 1'b0;
		end else if (ce) begin
			inta_r      <= st_nxt == H_ACK;
			cmd_valid_r <= issue;
			cmd_port_r  <= port_nxt;
			cmd_unit_r  <= cunit_nxt;
			cmd_reg_r   <= reg_nxt;
			cmd_data_r  <= data_nxt;
			svc_valid_r <= st_r == H_WAITV && lnk.vec_valid;
			ready_r     <= st_nxt == H_IDLE || ready_r;
			if (st_r == H_WAITV && lnk.vec_valid) begin
				svc_vec_r <= lnk.vec;
			end
		end
	end
endmodule

// ==== tb/cir_properties.sv ====
// Purpose: Link properties of the interrupt routing pair
// Assumes: One clock, sync active-high reset
// Notes:   Watches link signals and ce only
`timescale 1ns/1ps
module cir_properties
	import cir_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       ce,
	input wire logic       irq,
	input wire logic       inta,
	input wire logic       vec_valid,
	input wire logic [7:0] vec,
	input wire logic       cmd_valid,
	input wire cir_port_t  cmd_port,
	input wire logic [1:0] cmd_unit,
	input wire cir_reg_t   cmd_reg,
	input wire logic [7:0] cmd_data
);
	logic [7:0] last_vec_r;
	always_ff @(posedge clk) begin
		if (rst) begin
			last_vec_r <= 8'h00;
		end else if (vec_valid) begin
			last_vec_r <= vec;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_cascade_eoi;
		cmd_valid && cmd_port == CP_MASTER && cmd_data == EOI_CASCADE;
	endsequence
	sequence s_serial_eoi;
		cmd_reg == CR_WR0 && cmd_data == SER_EOI_CODE;
	endsequence
	sequence s_level1_eoi;
		cmd_valid && cmd_port == CP_MASTER && cmd_data == EOI_SERIAL_LVL;
	endsequence
	a_ack_answer: assert property (ce |=> vec_valid == $past(inta))
		else $error("answer not one cycle after ack");
	a_ack_spacing: assert property (ce && inta |=> !inta [*3])
		else $error("acks too close");
	a_freeze_hold: assert property (!ce |=> $stable({irq, inta, vec_valid, vec, cmd_valid}))
		else $error("link moved while frozen");
	a_vec_range: assert property (vec_valid |->
		vec inside {[8'h60:8'h66], [8'h68:8'h6f], [8'h70:8'h9f]})
		else $error("vector out of range");
	a_serial_even: assert property (vec_valid && vec >= VEC_SER_FIRST |-> !vec[0])
		else $error("serial vector odd");
	a_master_eoi: assert property (cmd_valid && cmd_port == CP_MASTER &&
		last_vec_r inside {[8'h60:8'h66]} |-> cmd_data == last_vec_r)
		else $error("master dismissal code wrong");
	a_slave_pair: assert property (ce && cmd_valid && cmd_port == CP_SLAVE |->
		(cmd_data == last_vec_r - 8'h08) ##1 s_cascade_eoi)
		else $error("slave dismissal order wrong");
	a_serial_pair: assert property (ce && cmd_valid && cmd_port == CP_SER_A |->
		s_serial_eoi ##1 s_level1_eoi)
		else $error("serial dismissal order wrong");
	a_serial_unit: assert property (cmd_valid && cmd_port == CP_SER_A |->
		cmd_unit == 2'(last_vec_r[7:4] - 4'h7))
		else $error("serial dismissal unit wrong");
	a_base_load: assert property (cmd_valid && cmd_reg == CR_WR2 |->
		cmd_port == CP_SER_B && cmd_data == 8'h70 + {2'b00, cmd_unit, 4'h0})
		else $error("vector base wrong");
	a_sav_load: assert property (cmd_valid && cmd_reg == CR_WR1 |->
		cmd_port == CP_SER_B && cmd_data[SAV_BIT])
		else $error("control word lacks vector status bit");
endmodule

// ==== tb/cascaded_irq_routing_eoi_tb_top.sv ====
// Purpose: Both ends joined, user sides driven and checked
// Assumes: 25 MHz clock, sync reset
// Notes:   Expected vectors from an integer model
`timescale 1ns/1ps
module cascaded_irq_routing_eoi_tb_top;
	import cir_pkg::*;
	logic            clk;
	logic            rst;
	logic            ce;
	logic            svc_done;
	logic [5:0]      mreq;
	logic [7:0]      sreq;
	logic [2:0][7:0] ser_req;
	logic [7:0]      m_isr_r;
	logic [7:0]      s_isr_r;
	logic [2:0]      ser_ius_r;
	logic [2:0]      ser_sav_r;
	logic            svc_valid_r;
	logic [7:0]      svc_vec_r;
	logic            ready_r;
	logic [37:0]     one;
	int              n_mismatch;
	int              compares;
	int              cycles;
	int              seed;
	int              exp_q[$];
	cir_if lnk ();
	cir_dev #(.N_SER(3)) i_cir_dev (.clk(clk), .rst(rst), .ce(ce), .lnk(lnk), .mreq(mreq),
		.sreq(sreq), .ser_req(ser_req), .m_isr_r(m_isr_r), .s_isr_r(s_isr_r),
		.ser_ius_r(ser_ius_r), .ser_sav_r(ser_sav_r));
	cir_host #(.N_SER(3)) i_cir_host (.clk(clk), .rst(rst), .ce(ce), .lnk(lnk),
		.svc_done(svc_done), .svc_valid_r(svc_valid_r), .svc_vec_r(svc_vec_r),
		.ready_r(ready_r));
	cir_properties i_cir_properties (.clk(clk), .rst(rst), .ce(ce), .irq(lnk.irq),
		.inta(lnk.inta),
		.vec_valid(lnk.vec_valid), .vec(lnk.vec), .cmd_valid(lnk.cmd_valid),
		.cmd_port(lnk.cmd_port), .cmd_unit(lnk.cmd_unit), .cmd_reg(lnk.cmd_reg),
		.cmd_data(lnk.cmd_data));
	always #20 clk = ~clk;
	task automatic give_verdict();
		if (n_mismatch == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Lower level wins; level 1 is the serial chain, level 7 the slave
	function automatic int expect_vec(input logic [5:0] m, input logic [7:0] s,
		input logic [23:0] r);
		if (m[0])
			return 'h60;
		for (int u = 0; u < 3; u++)
			for (int c = 0; c < 8; c++)
				if (r[u * 8 + c])
					return 'h70 + u * 'h10 + c * 2;
		for (int lv = 1; lv < 6; lv++)
			if (m[lv])
				return 'h61 + lv;
		for (int lv = 0; lv < 8; lv++)
			if (s[lv])
				return 'h68 + lv;
		return 'h6f;
	endfunction
	task automatic run_case(input logic [37:0] req, input int stall);
		int exp;
		int k;
		exp_q.push_back(expect_vec(req[5:0], req[13:6], req[37:14]));
		mreq <= req[5:0];
		sreq <= req[13:6];
		ser_req <= req[37:14];
		// Freeze both ends partway through the acknowledge
		if (stall > 0) begin
			repeat (stall) @(posedge clk);
			ce <= 1'b0;
			repeat (3) @(posedge clk);
			ce <= 1'b1;
		end
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (svc_valid_r !== 1'b1 && k < 60);
		if (svc_valid_r !== 1'b1) begin
			n_mismatch++;
			$display("Error at %0t: no vector delivered", $time);
		end
		exp = exp_q.pop_front();
		check(svc_vec_r, 8'(exp));
		@(posedge clk);
		mreq <= '0;
		sreq <= '0;
		ser_req <= '0;
		repeat (2) @(posedge clk);
		svc_done <= 1'b1;
		@(posedge clk);
		svc_done <= 1'b0;
		repeat (10) @(posedge clk);
		@(negedge clk);
		check(m_isr_r, 8'h00);
		check(s_isr_r, 8'h00);
		check({5'h00, ser_ius_r}, 8'h00);
		@(posedge clk);
	endtask
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		ce = 1'b1;
		svc_done = 1'b0;
		mreq = '0;
		sreq = '0;
		ser_req = '0;
		n_mismatch = 0;
		compares = 0;
		cycles = 0;
		seed = 97593;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (12) @(posedge clk);
		@(negedge clk);
		check({7'h00, ready_r}, 8'h01);
		check({5'h00, ser_sav_r}, 8'h07);
		@(posedge clk);
		// Every single source once
		for (int i = 0; i < 38; i++) begin
			one = 38'h1 << i;
			run_case(one, 0);
		end
		// Sparse random mixes
		for (int i = 0; i < 40; i++) begin
			one = 38'({$random(seed), $random(seed)} & {$random(seed), $random(seed)});
			one[i % 38] = 1'b1;
			run_case(one, i % 4);
		end
		give_verdict();
	end
endmodule
